/* core/mitc_pkg.sv */
// constants and types of the instruction timing core
`default_nettype none
// Overview of operation
// - one instruction cycle is four clock cycles; all timing counts in them.
// - ordinary ops take one cycle; jumps, calls, returns and table reads two.
// - writing the low program counter byte jumps there at one extra cycle.
// - a skip test costs one cycle, and one more when it does skip.
// - a true skip test passes over the next instruction, else it runs.
// - add sets carry above 255 and subtract sets it on a result below 0.
// - increment and decrement change by one, to memory or accumulator.
// - and, or, xor and complement set zero on a zero result, else clear it.
// - rotates move one bit; the carry forms swap the lost bit with carry.
// - bit set and clear change only the addressed bit of a memory byte.
// - a call saves the return address, the return resumes after the call.
// - moves carry bytes memory to accumulator, back, and immediate in.
// - table reads fetch program memory words into data registers.
// - add and subtract update zero, carry, aux, overflow and signed carry.
package mitc_pkg;

  localparam int ICYC_CLKS = 4;
  localparam logic [7:0] PCL_ADDR = 8'h02;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam int FLG_Z = 0;
  localparam int FLG_C = 1;
  localparam int FLG_AC = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_SC = 4;
  localparam int FLG_CZ = 5;
  localparam logic [5:0] MASK_ADD = 6'h1F;
  localparam logic [5:0] MASK_SUB = 6'h3F;
  localparam logic [5:0] MASK_Z = 6'h01;
  localparam logic [5:0] MASK_C = 6'h02;
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 11;

  typedef enum logic [4:0] {
    op_nop = 5'h00,
    op_add = 5'h01,
    op_adc = 5'h02,
    op_sub = 5'h03,
    op_sbc = 5'h04,
    op_and = 5'h05,
    op_or = 5'h06,
    op_xor = 5'h07,
    op_bitwise_complement = 5'h08,
    op_inc = 5'h09,
    op_dec = 5'h0A,
    op_ror = 5'h0B,
    op_rol = 5'h0C,
    op_rotate_right_through_carry = 5'h0D,
    op_rotate_left_through_carry = 5'h0E,
    op_move_to_acc = 5'h0F,
    op_move_to_mem = 5'h10,
    op_bit_set = 5'h11,
    op_bit_clear = 5'h12,
    op_skip_zero = 5'h13,
    op_skip_nonzero = 5'h14,
    op_skip_bit_zero = 5'h15,
    op_skip_bit_one = 5'h16,
    op_jump_unconditional = 5'h17,
    op_call = 5'h18,
    op_subroutine_back = 5'h19,
    op_interrupt_exit = 5'h1A,
    op_table_read = 5'h1B
  } mitc_op_type;

  typedef enum logic [1:0] {
    ph_fetch = 2'b00,
    ph_read = 2'b01,
    ph_write = 2'b10,
    ph_commit = 2'b11
  } mitc_phase_type;

endpackage
`default_nettype wire

/* core/mitc_alu.sv */
// eight bit datapath of the instruction timing core
`timescale 1ns/1ns
`default_nettype none
module mitc_alu (
  input wire mitc_pkg::mitc_op_type op,
  input wire logic [7:0] a,
  input wire logic [7:0] m,
  input wire logic [2:0] bidx,
  input wire logic cin,
  input wire logic czin,
  output logic [7:0] res,
  output logic [5:0] flags,
  output logic [5:0] fmask,
  output logic test
);
  import mitc_pkg::*;
  logic [8:0] sum;
  logic [4:0] lo;
  logic cy;
  logic [7:0] bmask;

  always_comb begin
    sum = 9'h000;
    lo = 5'h00;
    cy = 1'h0;
    bmask = 8'h01 << bidx;
    res = a;
    flags = 6'h00;
    fmask = 6'h00;
    test = 1'h0;
    case (op)
      op_add, op_adc: begin
        cy = (op == op_adc) & cin;
        sum = {1'h0, a} + {1'h0, m} + {8'h00, cy};
        lo = {1'h0, a[3:0]} + {1'h0, m[3:0]} + {4'h0, cy};
        res = sum[7:0];
        flags[FLG_C] = sum[8];
        flags[FLG_AC] = lo[4];
        flags[FLG_OV] = (a[7] == m[7]) && (res[7] != a[7]);
        fmask = MASK_ADD;
      end
      op_sub, op_sbc: begin
        cy = (op == op_sbc) & cin;
        sum = {1'h0, a} - {1'h0, m} - {8'h00, cy};
        lo = {1'h0, a[3:0]} - {1'h0, m[3:0]} - {4'h0, cy};
        res = sum[7:0];
        flags[FLG_C] = sum[8];
        flags[FLG_AC] = lo[4];
        flags[FLG_OV] = (a[7] != m[7]) && (res[7] != a[7]);
        flags[FLG_CZ] = (res == 8'h00) && ((op == op_sub) || czin);
        fmask = MASK_SUB;
      end
      op_and: begin
        res = a & m;
        fmask = MASK_Z;
      end
      op_or: begin
        res = a | m;
        fmask = MASK_Z;
      end
      op_xor: begin
        res = a ^ m;
        fmask = MASK_Z;
      end
      op_bitwise_complement: begin
        res = ~m;
        fmask = MASK_Z;
      end
      op_inc: begin
        res = m + 8'h01;
        fmask = MASK_Z;
      end
      op_dec: begin
        res = m - 8'h01;
        fmask = MASK_Z;
      end
      op_ror: res = {m[0], m[7:1]};
      op_rol: res = {m[6:0], m[7]};
      op_rotate_right_through_carry: begin
        res = {cin, m[7:1]};
        flags[FLG_C] = m[0];
        fmask = MASK_C;
      end
      op_rotate_left_through_carry: begin
        res = {m[6:0], cin};
        flags[FLG_C] = m[7];
        fmask = MASK_C;
      end
      op_move_to_acc: res = m;
      op_move_to_mem: res = a;
      op_bit_set: res = m | bmask;
      op_bit_clear: res = m & ~bmask;
      op_skip_zero: test = (m == 8'h00);
      op_skip_nonzero: test = (m != 8'h00);
      op_skip_bit_zero: test = ((m & bmask) == 8'h00);
      op_skip_bit_one: test = ((m & bmask) != 8'h00);
      default: res = a;
    endcase
    flags[FLG_Z] = (res == 8'h00);
    flags[FLG_SC] = flags[FLG_OV] ^ res[7];
  end
endmodule // mitc_alu
`default_nettype wire

/* core/mitc_core.sv */
// instruction sequencer with prefetch, stack and table read
`timescale 1ns/1ns
`default_nettype none
module mitc_core #(
  parameter int PC_W = 11,
  parameter int STACK_DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic [PC_W-1:0] pmem_addr,
  input wire logic [15:0] pmem_rdata,
  output logic [7:0] dmem_addr,
  input wire logic [7:0] dmem_rdata,
  output logic [7:0] dmem_wdata,
  output logic dmem_we,
  output logic [7:0] acc,
  output logic [5:0] status,
  output logic [7:0] table_high,
  output logic icyc_start
);
  import mitc_pkg::*;
  localparam int SP_W = $clog2(STACK_DEPTH);

  mitc_phase_type phase_ff, nxt_phase;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [15:0] ir_ff, nxt_ir;
  logic bub_ff, nxt_bub;
  logic [7:0] acc_ff, nxt_acc;
  logic [5:0] flags_ff, nxt_flags;
  logic [7:0] res_ff, nxt_res;
  logic [7:0] tblh_ff, nxt_tblh;
  logic [5:0] rflg_ff, nxt_rflg;
  logic [SP_W-1:0] sp_ff, nxt_sp;
  logic [PC_W-1:0] stk_ff [STACK_DEPTH];
  logic [PC_W-1:0] nxt_stk [STACK_DEPTH];

  mitc_op_type op;
  logic [7:0] mfield;
  logic [PC_W-1:0] pc_cur;
  logic [PC_W-1:0] tbl_addr;
  logic bitop, imm_use, exec, tbl_bub;
  logic to_mem, to_acc, pcl_wr, transfer, skip_taken, flush;
  logic [7:0] opnd;
  logic [7:0] alu_res;
  logic [5:0] alu_flags, alu_mask;
  logic alu_test;

  // instruction word fields
  always_comb begin
    op = mitc_op_type'(ir_ff[OPC_MSB:OPC_LSB]);
    mfield = ir_ff[7:0];
    pc_cur = pc_ff - PC_W'(1);
    tbl_addr = {pc_ff[PC_W-1:8], acc_ff};
    bitop = (op == op_bit_set) || (op == op_bit_clear) ||
            (op == op_skip_bit_zero) || (op == op_skip_bit_one);
    imm_use = ir_ff[9] && !bitop;
    exec = !bub_ff;
    tbl_bub = bub_ff && (op == op_table_read);
    to_mem = 1'h0;
    to_acc = 1'h0;
    unique case (op)
      op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_xor,
      op_bitwise_complement, op_inc, op_dec, op_ror, op_rol,
      op_rotate_right_through_carry, op_rotate_left_through_carry: begin
        to_mem = ir_ff[10] && !imm_use;
        to_acc = !to_mem;
      end
      op_move_to_acc: to_acc = 1'h1;
      op_move_to_mem, op_bit_set, op_bit_clear: to_mem = 1'h1;
      default: begin
        to_mem = 1'h0;
        to_acc = 1'h0;
      end
    endcase
    pcl_wr = exec && to_mem && (mfield == PCL_ADDR);
    transfer = (op == op_jump_unconditional) || (op == op_call) ||
               (op == op_subroutine_back) || (op == op_interrupt_exit);
    skip_taken = exec && alu_test;
    flush = exec && (transfer || (op == op_table_read) || pcl_wr ||
            alu_test);
    if (imm_use) begin
      opnd = mfield;
    end else if (mfield == PCL_ADDR) begin
      opnd = pc_cur[7:0];
    end else begin
      opnd = dmem_rdata;
    end
  end

  mitc_alu u_alu (
    .op(op),
    .a(acc_ff),
    .m(opnd),
    .bidx(ir_ff[10:8]),
    .cin(flags_ff[FLG_C]),
    .czin(flags_ff[FLG_CZ]),
    .res(alu_res),
    .flags(alu_flags),
    .fmask(alu_mask),
    .test(alu_test)
  );

  assign pmem_addr = (tbl_bub && !phase_ff[1]) ? tbl_addr : pc_ff;
  assign dmem_addr = mfield;
  assign dmem_wdata = res_ff;
  assign dmem_we = (phase_ff == ph_write) &&
                   ((exec && to_mem && !pcl_wr) || tbl_bub);
  assign acc = acc_ff;
  assign status = flags_ff;
  assign table_high = tblh_ff;
  assign icyc_start = (phase_ff == ph_fetch);

  always_comb begin
    nxt_phase = phase_ff;
    nxt_pc = pc_ff;
    nxt_ir = ir_ff;
    nxt_bub = bub_ff;
    nxt_acc = acc_ff;
    nxt_flags = flags_ff;
    nxt_res = res_ff;
    nxt_tblh = tblh_ff;
    nxt_rflg = rflg_ff;
    nxt_sp = sp_ff;
    nxt_stk = stk_ff;
    unique case (phase_ff)
      ph_fetch: nxt_phase = ph_read;
      ph_read: begin
        nxt_phase = ph_write;
        if (tbl_bub) begin
          nxt_res = pmem_rdata[7:0];
          nxt_tblh = pmem_rdata[15:8];
        end else begin
          nxt_res = alu_res;
          // flags taken before memory write back
          nxt_rflg = alu_flags;
        end
      end
      ph_write: nxt_phase = ph_commit;
      ph_commit: begin
        nxt_phase = ph_fetch;
        nxt_bub = flush;
        if (!flush) begin
          nxt_ir = pmem_rdata;
        end
        nxt_pc = pc_ff + PC_W'(1);
        if (exec) begin
          if (to_acc) begin
            nxt_acc = res_ff;
          end
          nxt_flags = (flags_ff & ~alu_mask) | (rflg_ff & alu_mask);
          unique case (op)
            op_jump_unconditional: nxt_pc = ir_ff[PC_W-1:0];
            op_call: begin
              nxt_stk[sp_ff] = pc_ff;
              nxt_sp = sp_ff + SP_W'(1);
              nxt_pc = ir_ff[PC_W-1:0];
            end
            op_subroutine_back, op_interrupt_exit: begin
              nxt_sp = sp_ff - SP_W'(1);
              nxt_pc = stk_ff[sp_ff - SP_W'(1)];
            end
            op_table_read: nxt_pc = pc_ff;
            default: begin
              if (pcl_wr) begin
                nxt_pc = {pc_ff[PC_W-1:8], res_ff};
              end
            end
          endcase
          if (skip_taken) begin
            nxt_pc = pc_ff + PC_W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= ph_fetch;
      pc_ff <= '0;
      ir_ff <= 16'h0000;
      bub_ff <= 1'h1;
      acc_ff <= ACC_RST;
      flags_ff <= FLAGS_RST;
      res_ff <= 8'h00;
      tblh_ff <= 8'h00;
      rflg_ff <= 6'h00;
      sp_ff <= '0;
    end else begin
      phase_ff <= nxt_phase;
      pc_ff <= nxt_pc;
      ir_ff <= nxt_ir;
      bub_ff <= nxt_bub;
      acc_ff <= nxt_acc;
      flags_ff <= nxt_flags;
      res_ff <= nxt_res;
      tblh_ff <= nxt_tblh;
      rflg_ff <= nxt_rflg;
      sp_ff <= nxt_sp;
    end
  end

  // return stack storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stk_ff[i] <= '0;
      end
    end else begin
      stk_ff <= nxt_stk;
    end
  end
endmodule // mitc_core
`default_nettype wire

/* tb/mitc_core_assertions.sv */
// port checker of the instruction timing core
`timescale 1ns/1ns
`default_nettype none
module mitc_core_checker #(
  parameter int PC_W = 11
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [PC_W-1:0] pmem_addr,
  input wire logic [7:0] dmem_addr,
  input wire logic dmem_we,
  input wire logic [7:0] acc,
  input wire logic [5:0] status,
  input wire logic icyc_start
);
  import mitc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_icyc_four_clk: assert property (
    icyc_start |=> !icyc_start [*3] ##1 icyc_start)
    else $error("cycle not four clocks");
  a_we_phase_two: assert property (
    dmem_we |-> $past(icyc_start, 2) && !icyc_start)
    else $error("write outside phase two");
  a_we_one_pulse: assert property (
    dmem_we |=> !dmem_we [*3])
    else $error("second write in cycle");
  a_pcl_no_write: assert property (
    dmem_we |-> dmem_addr != PCL_ADDR)
    else $error("pc low write reached memory");
  a_daddr_hold: assert property (
    !icyc_start |-> $stable(dmem_addr))
    else $error("data address moved");
  a_paddr_late_hold: assert property (
    $past(icyc_start, 3) |-> $stable(pmem_addr))
    else $error("fetch address moved late");
  a_paddr_moves: assert property (
    $changed(pmem_addr) |-> icyc_start || $past(icyc_start, 2))
    else $error("fetch address moved mid cycle");
  a_regs_commit: assert property (
    !icyc_start |-> $stable(acc) && $stable(status))
    else $error("state changed mid cycle");
  c_write: cover property (dmem_we);
  c_table: cover property ($changed(pmem_addr) && !icyc_start);
  c_acc: cover property (icyc_start && $changed(acc));
endmodule // mitc_core_checker
bind mitc_core mitc_core_checker #(.PC_W(PC_W)) mitc_core_checker_i (
  .clk(clk), .arst_n(arst_n), .pmem_addr(pmem_addr),
  .dmem_addr(dmem_addr), .dmem_we(dmem_we), .acc(acc),
  .status(status), .icyc_start(icyc_start));
`default_nettype wire

/* tb/mitc_mem_model.sv */
// program and data memory beside the core
`timescale 1ns/1ns
`default_nettype none
module mitc_mem_model #(
  parameter int PC_W = 11
) (
  input wire logic clk,
  input wire logic [PC_W-1:0] pmem_addr,
  output logic [15:0] pmem_rdata,
  input wire logic [7:0] dmem_addr,
  output logic [7:0] dmem_rdata,
  input wire logic [7:0] dmem_wdata,
  input wire logic dmem_we
);
  logic [15:0] pm [2**PC_W];
  logic [7:0] dm [256];
  assign pmem_rdata = pm[pmem_addr];
  assign dmem_rdata = dm[dmem_addr];
  always @(posedge clk) begin
    if (dmem_we) begin
      dm[dmem_addr] <= dmem_wdata;
    end
  end
  task automatic clear;
    for (int i = 0; i < 2**PC_W; i++) begin
      pm[i] = 16'h0000;
    end
    for (int i = 0; i < 256; i++) begin
      dm[i] = 8'h00;
    end
  endtask
endmodule // mitc_mem_model
`default_nettype wire

/* tb/mitc_core_tb.sv */
// self-checking bench of the instruction timing core
`timescale 1ns/1ns
`default_nettype none
module mitc_core_tb;
  import mitc_pkg::*;
  logic clk;
  logic arst_n;
  logic [10:0] pmem_addr;
  logic [15:0] pmem_rdata;
  logic [7:0] dmem_addr;
  logic [7:0] dmem_rdata;
  logic [7:0] dmem_wdata;
  logic dmem_we;
  logic [7:0] acc;
  logic [5:0] status;
  logic [7:0] table_high;
  logic icyc_start;
  int n_fail;
  int cmp_count;
  mitc_core mitc_core_i (.clk(clk), .arst_n(arst_n),
    .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata),
    .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
    .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .acc(acc),
    .status(status), .table_high(table_high), .icyc_start(icyc_start));
  mitc_mem_model mitc_mem_model_i (.clk(clk), .pmem_addr(pmem_addr),
    .pmem_rdata(pmem_rdata), .dmem_addr(dmem_addr),
    .dmem_rdata(dmem_rdata), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] ins(mitc_op_type o, logic [2:0] f,
      logic [7:0] v);
    return {o, f, v};
  endfunction
  function automatic logic [15:0] mv(logic [7:0] v);
    return ins(op_move_to_acc, 3'h2, v);
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ld(int a, logic [15:0] w);
    mitc_mem_model_i.pm[a] = w;
  endtask
  task automatic hold;
    @(posedge clk);
    #1 arst_n = 1'b0;
    mitc_mem_model_i.clear();
  endtask
  task automatic go;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
  endtask
  // clocks from release until the marker lands in acc
  task automatic run_time(int nexp);
    int n;
    n = 0;
    go();
    while (acc !== 8'hA5 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk("clocks", 16'(nexp), 16'(n));
  endtask
  task automatic alu(mitc_op_type o, logic [2:0] f, logic [7:0] v,
      logic [7:0] d, logic [7:0] a0, logic [7:0] ea, logic [7:0] ed,
      logic [5:0] es);
    hold();
    mitc_mem_model_i.dm[8'h30] = d;
    ld(0, mv(a0));
    ld(1, ins(o, f, v));
    go();
    repeat (12) @(posedge clk);
    #1 chk("acc", 16'(ea), 16'(acc));
    chk("mem", 16'(ed), 16'(mitc_mem_model_i.dm[8'h30]));
    chk("status", 16'(es), 16'(status));
  endtask
  task automatic t_branch;
    hold();
    ld(0, mv(8'h11));
    ld(1, mv(8'hA5));
    run_time(12);
    hold();
    ld(0, ins(op_jump_unconditional, 3'h0, 8'h03));
    ld(1, mv(8'hEE));
    ld(3, mv(8'hA5));
    run_time(16);
    hold();
    ld(0, mv(8'h04));
    ld(1, ins(op_move_to_mem, 3'h4, 8'h02));
    ld(2, mv(8'hEE));
    ld(4, mv(8'hA5));
    run_time(20);
  endtask
  task automatic t_skip;
    for (int i = 0; i < 8; i++) begin
      hold();
      mitc_mem_model_i.dm[8'h30] = 8'(i / 4);
      ld(0, ins(mitc_op_type'(5'h13 + i % 4), 3'h0, 8'h30));
      ld(1, mv(8'hA5));
      ld(2, mv(8'hA5));
      run_time(ICYC_CLKS * (((i % 2) ^ (i / 4)) != 0 ? 3 : 4));
    end
  endtask
  task automatic t_call;
    for (int i = 0; i < 2; i++) begin
      hold();
      ld(0, ins(op_call, 3'h0, 8'h04));
      ld(1, mv(8'hA5));
      ld(4, ins(i ? op_interrupt_exit : op_subroutine_back, 3'h0, 8'h00));
      run_time(24);
    end
  endtask
  task automatic t_table;
    hold();
    ld(0, mv(8'h40));
    ld(1, ins(op_table_read, 3'h0, 8'h31));
    ld(2, mv(8'hA5));
    ld(8'h40, 16'hBEEF);
    run_time(20);
    chk("table_high", 16'h00BE, 16'(table_high));
    chk("table_low", 16'h00EF, 16'(mitc_mem_model_i.dm[8'h31]));
  endtask
  task automatic t_arith;
    alu(op_add, 3'h2, 8'h20, 8'h00, 8'hF0, 8'h10, 8'h00, 6'h02);
    alu(op_adc, 3'h2, 8'h01, 8'h00, 8'hFF, 8'h00, 8'h00, 6'h07);
    alu(op_sbc, 3'h2, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 6'h01);
    alu(op_sub, 3'h2, 8'h20, 8'h00, 8'h10, 8'hF0, 8'h00, 6'h12);
    alu(op_sub, 3'h2, 8'h33, 8'h00, 8'h33, 8'h00, 8'h00, 6'h21);
    alu(op_inc, 3'h0, 8'h30, 8'h7F, 8'h00, 8'h80, 8'h7F, 6'h00);
    alu(op_dec, 3'h4, 8'h30, 8'h01, 8'h00, 8'h00, 8'h00, 6'h01);
  endtask
  task automatic t_logic;
    alu(op_and, 3'h2, 8'h0F, 8'h00, 8'hF0, 8'h00, 8'h00, 6'h01);
    alu(op_xor, 3'h2, 8'h55, 8'h00, 8'hAA, 8'hFF, 8'h00, 6'h00);
    alu(op_or, 3'h2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 6'h01);
    alu(op_bitwise_complement, 3'h0, 8'h30, 8'hFF, 8'h12, 8'h00, 8'hFF,
      6'h01);
  endtask
  task automatic t_rot_move;
    alu(op_rotate_left_through_carry, 3'h4, 8'h30, 8'h81, 8'h00, 8'h00,
      8'h02, 6'h02);
    alu(op_ror, 3'h0, 8'h30, 8'h01, 8'h00, 8'h80, 8'h01, 6'h00);
    alu(op_rol, 3'h0, 8'h30, 8'h81, 8'h00, 8'h03, 8'h81, 6'h00);
    alu(op_rotate_right_through_carry, 3'h0, 8'h30, 8'h01, 8'h00, 8'h00,
      8'h01, 6'h02);
    alu(op_move_to_acc, 3'h0, 8'h30, 8'h5C, 8'h00, 8'h5C, 8'h5C,
      6'h00);
    alu(op_move_to_mem, 3'h4, 8'h30, 8'h00, 8'h3C, 8'h3C, 8'h3C,
      6'h00);
    alu(op_bit_set, 3'h5, 8'h30, 8'h00, 8'h00, 8'h00, 8'h20, 6'h00);
    alu(op_bit_clear, 3'h0, 8'h30, 8'hFF, 8'h00, 8'h00, 8'hFE, 6'h00);
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    arst_n = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    t_branch();
    t_skip();
    t_call();
    t_table();
    t_arith();
    t_logic();
    t_rot_move();
    tally_and_finish();
  end
endmodule // mitc_core_tb
`default_nettype wire
